/* File: hw/tld_map.vh */
// Operation
// (RQ1) braking rate slopes final segment, position mode
// (RQ2) speed ceiling is middle segment cruise speed
// (RQ3) three segments; setpoint never above ceiling
// (RQ4) speed ceiling resets to 0x7FFFFFF
// (RQ5) settled target: zero speed inside band
// (RQ6) warning bit 6 clears when inside band
// (RQ7) settle band resets to one
// (RQ8) encoder ratio is unsigned 16.16 fixed point
// (RQ9) rates always in first encoder units
// (RQ10) store commands copy four registers out
// (RQ11) host lowers braking rate on overshoot
// (RQ12) acceleration slopes first segment
// (RQ13) limit registers clamped to non-negative; accel writes are stored unclamped
// (RQ14) new values act next regulation cycle
`ifndef TLD_MAP_VH
`define TLD_MAP_VH
// ****************************************
// register offsets
// ****************************************
`define TLD_OFS_ACCEL      8'h40
`define TLD_OFS_BRAKE      8'h41
`define TLD_OFS_CEIL       8'h42
`define TLD_OFS_BAND       8'h43
`define TLD_OFS_RATIO      8'h44
`define TLD_OFS_MODE       8'h50
`define TLD_OFS_TARGET     8'h51
`define TLD_OFS_WARN       8'h52
`define TLD_OFS_SETPT      8'h53
`define TLD_OFS_IRQ_STAT   8'h54
`define TLD_OFS_IRQ_CLR    8'h55
`define TLD_OFS_IRQ_EN     8'h56
`define TLD_OFS_STORE      8'h57
// ****************************************
// reset values and fields
// ****************************************
`define TLD_RST_ACCEL      32'h00000000
`define TLD_RST_BRAKE      32'h00000000
`define TLD_RST_CEIL       32'h07FFFFFF
`define TLD_RST_BAND       32'h00000001
`define TLD_RST_RATIO      32'h00010000
`define TLD_WARN_NREACH    6
`define TLD_MODE_STANDBY   2'h0
`define TLD_MODE_POS       2'h1
`define TLD_MODE_SPD       2'h2
`define TLD_STORE_USER     0
`define TLD_STORE_FACT     1
`define TLD_NVM_WORDS      3'h4
`define TLD_IRQ_SETTLED    0
`define TLD_IRQ_NREACH     1
`define TLD_IRQ_STORED     2
`define TLD_RATE_SHIFT     16
`endif

/* File: hw/tld_nvm_copy.v */
`timescale 1ns/1ps
`include "tld_map.vh"
// ****************************************
// nonvolatile copy sequencer
// ****************************************
module tld_nvm_copy (
  // clock and reset
  input  wire        i_ref_clk,
  input  wire        i_srst,
  // trigger and source words
  input  wire        i_start,
  input  wire        i_factory,
  input  wire [31:0] i_word0,
  input  wire [31:0] i_word1,
  input  wire [31:0] i_word2,
  input  wire [31:0] i_word3,
  // storage write port
  output reg         o_nvm_we,
  output reg         o_nvm_bank,
  output reg  [1:0]  o_nvm_addr,
  output reg  [31:0] o_nvm_data,
  output reg         o_busy,
  output reg         o_done
);
  reg [2:0]  cnt_reg;
  reg [31:0] snap_reg [0:3];
  reg [31:0] word_sel;
  always @* begin
    case (cnt_reg[1:0])
      2'h0: word_sel = snap_reg[0];
      2'h1: word_sel = snap_reg[1];
      2'h2: word_sel = snap_reg[2];
      default: word_sel = snap_reg[3];
    endcase
  end
  // snapshot first so a write mid-copy cannot tear the saved set
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      cnt_reg    <= 3'h0;
      o_nvm_we   <= 1'b0;
      o_nvm_bank <= 1'b0;
      o_nvm_addr <= 2'h0;
      o_nvm_data <= 32'h00000000;
      o_busy     <= 1'b0;
      o_done     <= 1'b0;
    end else begin
      o_done   <= 1'b0;
      o_nvm_we <= 1'b0;
      if (!o_busy && i_start) begin
        snap_reg[0] <= i_word0; // RQ10
        snap_reg[1] <= i_word1;
        snap_reg[2] <= i_word2;
        snap_reg[3] <= i_word3;
        o_nvm_bank  <= i_factory;
        cnt_reg     <= 3'h0;
        o_busy      <= 1'b1;
      end else if (o_busy) begin
        if (cnt_reg == `TLD_NVM_WORDS) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end else begin
          o_nvm_we   <= 1'b1; // RQ10
          o_nvm_addr <= cnt_reg[1:0];
          o_nvm_data <= word_sel;
          cnt_reg    <= cnt_reg + 3'h1;
        end
      end
    end
  end
endmodule

/* File: hw/tld_top.v */
`timescale 1ns/1ps
`include "tld_map.vh"
// ****************************************
// trajectory limits and settle band
// ****************************************
module tld_top (
  // clock and reset
  input  wire        i_ref_clk,
  input  wire        i_srst,
  // register port
  input  wire [7:0]  i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [31:0] o_rdata,
  // regulation loop
  input  wire        i_reg_tick,
  input  wire [31:0] i_meas_pos,
  input  wire [31:0] i_meas_spd,
  output reg  [31:0] o_setpoint_spd,
  output reg  [1:0]  o_segment,
  output reg         o_warn_nreach,
  output reg  [31:0] o_ratio,
  // nonvolatile storage
  output wire        o_nvm_we,
  output wire        o_nvm_bank,
  output wire [1:0]  o_nvm_addr,
  output wire [31:0] o_nvm_data,
  // interrupt
  output reg         o_irq
);
  localparam SEG_IDLE  = 2'h0;
  localparam SEG_RAMP  = 2'h1;
  localparam SEG_CRUISE = 2'h2;
  localparam SEG_BRAKE = 2'h3;

  // ****************************************
  // software registers
  // ****************************************
  reg [31:0] accel_reg, brake_reg, ceil_reg, band_reg, ratio_reg, target_reg;
  reg [1:0]  loop_sel_reg;
  reg [2:0]  irq_stat_reg, irq_en_reg;
  // shadows picked up only on a regulation tick
  reg [31:0] accel_act, brake_act, ceil_act, band_act;
  reg [31:0] spd_reg;
  reg [1:0]  seg_reg;
  reg        settled_reg;
  reg [1:0]  store_pulse;
  wire       nvm_busy, nvm_done;
  // negative writes clamp to zero
  wire [31:0] wclamp = i_wdata[31] ? 32'h00000000 : i_wdata; // RQ13

  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      accel_reg    <= `TLD_RST_ACCEL;
      brake_reg    <= `TLD_RST_BRAKE;
      ceil_reg     <= `TLD_RST_CEIL; // RQ4
      band_reg     <= `TLD_RST_BAND; // RQ7
      ratio_reg    <= `TLD_RST_RATIO;
      target_reg   <= 32'h00000000;
      loop_sel_reg <= `TLD_MODE_STANDBY;
      irq_en_reg   <= 3'h0;
      store_pulse  <= 2'h0;
    end else begin
      store_pulse <= 2'h0;
      if (i_wr) begin
        case (i_addr)
          `TLD_OFS_ACCEL:  accel_reg <= i_wdata;
          `TLD_OFS_BRAKE:  brake_reg <= wclamp; // RQ13
          `TLD_OFS_CEIL:   ceil_reg  <= wclamp; // RQ13
          `TLD_OFS_BAND:   band_reg  <= wclamp; // RQ13
          `TLD_OFS_RATIO:  ratio_reg <= i_wdata; // RQ8
          `TLD_OFS_MODE:   loop_sel_reg <= i_wdata[1:0];
          `TLD_OFS_TARGET: target_reg <= i_wdata;
          `TLD_OFS_IRQ_EN: irq_en_reg <= i_wdata[2:0];
          `TLD_OFS_STORE:  store_pulse <= i_wdata[1:0];
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      case (i_addr)
        `TLD_OFS_ACCEL:    o_rdata <= accel_reg;
        `TLD_OFS_BRAKE:    o_rdata <= brake_reg;
        `TLD_OFS_CEIL:     o_rdata <= ceil_reg;
        `TLD_OFS_BAND:     o_rdata <= band_reg;
        `TLD_OFS_RATIO:    o_rdata <= ratio_reg;
        `TLD_OFS_MODE:     o_rdata <= {30'h0, loop_sel_reg};
        `TLD_OFS_TARGET:   o_rdata <= target_reg;
        `TLD_OFS_WARN:     o_rdata <= {25'h0, o_warn_nreach, 6'h00};
        `TLD_OFS_SETPT:    o_rdata <= spd_reg;
        `TLD_OFS_IRQ_STAT: o_rdata <= {29'h0, irq_stat_reg};
        `TLD_OFS_IRQ_EN:   o_rdata <= {29'h0, irq_en_reg};
        `TLD_OFS_STORE:    o_rdata <= {31'h0, nvm_busy};
        default:           o_rdata <= 32'h00000000;
      endcase
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

  // ****************************************
  // band checks
  // ****************************************
  wire        pos_mode = (loop_sel_reg == `TLD_MODE_POS);
  wire        spd_mode = (loop_sel_reg == `TLD_MODE_SPD);
  wire [31:0] meas = pos_mode ? i_meas_pos : i_meas_spd;
  wire signed [32:0] lo_b = $signed({target_reg[31], target_reg}) - $signed({1'b0, band_act});
  wire signed [32:0] hi_b = $signed({target_reg[31], target_reg}) + $signed({1'b0, band_act});
  wire signed [32:0] meas_s = $signed({meas[31], meas});
  wire in_band = (meas_s >= lo_b) && (meas_s <= hi_b);
  wire signed [32:0] dist_s = $signed({target_reg[31], target_reg}) - $signed({i_meas_pos[31], i_meas_pos});
  wire [32:0] dist_abs = dist_s[32] ? (~dist_s + 33'h1) : dist_s;
  wire [31:0] spd_dir = dist_s[32] ? (~spd_reg + 32'h1) : spd_reg;

  // braking distance v*v/(2*dec), compared as v*v >= 2*dec*dist
  wire [63:0] v_sq    = {32'h0, spd_reg} * {32'h0, spd_reg};
  wire [95:0] brk_lhs = {32'h0, v_sq};
  wire [95:0] brk_rhs = {63'h0, brake_act, 1'b0} * {64'h0, dist_abs[31:0]};
  wire        need_brake = (brk_lhs >= brk_rhs);
  // rates per tick: rate in units/s^2 scaled by shift, first encoder units
  wire [31:0] acc_step = (accel_act >> `TLD_RATE_SHIFT) | 32'h1; // RQ9
  wire [31:0] brk_step = (brake_act >> `TLD_RATE_SHIFT) | 32'h1; // RQ9
  wire [32:0] up_sum   = {1'b0, spd_reg} + {1'b0, acc_step};
  wire [31:0] up_spd   = (up_sum > {1'b0, ceil_act}) ? ceil_act : up_sum[31:0]; // RQ3
  wire [31:0] dn_spd   = (spd_reg > brk_step) ? spd_reg - brk_step : 32'h00000000;

  // ****************************************
  // trajectory engine
  // ****************************************
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      accel_act      <= `TLD_RST_ACCEL;
      brake_act      <= `TLD_RST_BRAKE;
      ceil_act       <= `TLD_RST_CEIL;
      band_act       <= `TLD_RST_BAND;
      spd_reg        <= 32'h00000000;
      seg_reg        <= SEG_IDLE;
      settled_reg    <= 1'b0;
      o_setpoint_spd <= 32'h00000000;
      o_segment      <= SEG_IDLE;
      o_warn_nreach  <= 1'b1;
      o_ratio        <= `TLD_RST_RATIO;
    end else if (i_reg_tick) begin
      accel_act <= accel_reg; // RQ14
      brake_act <= brake_reg; // RQ14
      ceil_act  <= ceil_reg;  // RQ14
      band_act  <= band_reg;  // RQ14
      o_ratio   <= ratio_reg; // RQ8
      if (pos_mode || spd_mode) begin
        o_warn_nreach <= ~in_band; // RQ6
      end else begin
        o_warn_nreach <= 1'b1;
      end
      if (pos_mode && dist_abs == 33'h0) begin
        settled_reg <= 1'b1;
      end else if (!pos_mode || !in_band) begin
        settled_reg <= 1'b0;
      end
      // hold-off zone kills chatter around the target
      if (!pos_mode) begin
        seg_reg <= SEG_IDLE;
        spd_reg <= 32'h00000000;
      end else if ((settled_reg || dist_abs == 33'h0) && in_band) begin
        seg_reg <= SEG_IDLE; // RQ5
        spd_reg <= 32'h00000000; // RQ5
      end else begin
        case (seg_reg)
          SEG_IDLE: begin
            seg_reg <= SEG_RAMP;
          end
          SEG_RAMP: begin
            spd_reg <= up_spd; // RQ12
            if (need_brake) begin
              seg_reg <= SEG_BRAKE;
            end else if (up_spd == ceil_act) begin
              seg_reg <= SEG_CRUISE;
            end
          end
          SEG_CRUISE: begin
            spd_reg <= ceil_act; // RQ2
            if (need_brake) begin
              seg_reg <= SEG_BRAKE;
            end
          end
          SEG_BRAKE: begin
            spd_reg <= dn_spd; // RQ1
            if (dn_spd == 32'h00000000) begin
              seg_reg <= SEG_IDLE;
            end
          end
          default: seg_reg <= SEG_IDLE;
        endcase
      end
      o_setpoint_spd <= (spd_reg > ceil_act) ? ceil_act : spd_dir; // RQ3
      o_segment      <= seg_reg;
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  reg        warn_d;
  wire [2:0] irq_set = {nvm_done, (o_warn_nreach & ~warn_d), (~o_warn_nreach & warn_d)};
  wire [2:0] irq_clr = (i_wr && i_addr == `TLD_OFS_IRQ_CLR) ? i_wdata[2:0] : 3'h0;
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      warn_d       <= 1'b1;
      irq_stat_reg <= 3'h0;
      o_irq        <= 1'b0;
    end else begin
      warn_d       <= o_warn_nreach;
      // a set in the clear cycle wins
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      o_irq        <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_en_reg);
    end
  end

  // ****************************************
  // nonvolatile store
  // ****************************************
  tld_nvm_copy u_nvm (
    .i_ref_clk  (i_ref_clk),
    .i_srst     (i_srst),
    .i_start    (|store_pulse),
    .i_factory  (store_pulse[`TLD_STORE_FACT]),
    .i_word0    (brake_reg),
    .i_word1    (ceil_reg),
    .i_word2    (band_reg),
    .i_word3    (ratio_reg),
    .o_nvm_we   (o_nvm_we),
    .o_nvm_bank (o_nvm_bank),
    .o_nvm_addr (o_nvm_addr),
    .o_nvm_data (o_nvm_data),
    .o_busy     (nvm_busy),
    .o_done     (nvm_done)
  );
endmodule

/* File: test/tld_top_props.sv */
`timescale 1ns/1ps
// ****************************************
// port checker
// ****************************************
module tld_top_props (
  // clock and reset
  input wire        i_ref_clk,
  input wire        i_srst,
  // register port
  input wire [7:0]  i_addr,
  input wire [31:0] i_wdata,
  input wire        i_wr,
  input wire        i_rd,
  input wire [31:0] o_rdata,
  // regulation loop
  input wire        i_reg_tick,
  input wire [31:0] o_setpoint_spd,
  input wire [1:0]  o_segment,
  input wire        o_warn_nreach,
  input wire [31:0] o_ratio,
  // storage
  input wire        o_nvm_we,
  input wire [1:0]  o_nvm_addr
);
  // shadow of the limit words and ratio, negatives stored as zero except for the ratio
  logic [31:0] sh_reg [1:4];
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      sh_reg[1] <= 32'h00000000;
      sh_reg[2] <= 32'h07FFFFFF;
      sh_reg[3] <= 32'h00000001;
      sh_reg[4] <= 32'h00010000;
    end else if (i_wr && i_addr >= 8'h41 && i_addr <= 8'h44) begin
      sh_reg[i_addr[2:0]] <= (i_addr != 8'h44 && i_wdata[31]) ? 32'h00000000 : i_wdata;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  rd_limits_a: assert property (i_rd && i_addr >= 8'h41 && i_addr <= 8'h43
    |=> o_rdata == $past(sh_reg[i_addr[2:0]])) else $error("limit read wrong");
  rd_ratio_a: assert property (i_rd && i_addr == 8'h44
    |=> o_rdata == $past(sh_reg[4])) else $error("ratio read wrong");
  ratio_tick_a: assert property (i_reg_tick |=> o_ratio == $past(sh_reg[4]))
    else $error("ratio not taken on tick");
  ratio_hold_a: assert property (!i_reg_tick |=> $stable(o_ratio))
    else $error("ratio moved off tick");
  seg_hold_a: assert property (!i_reg_tick |=> $stable(o_segment))
    else $error("segment moved off tick");
  spd_hold_a: assert property (!i_reg_tick |=> $stable(o_setpoint_spd))
    else $error("setpoint moved off tick");
  spd_cap_a: assert property ($signed(o_setpoint_spd) <= 32'sh07FFFFFF &&
    $signed(o_setpoint_spd) >= -32'sh07FFFFFF) else $error("setpoint above ceiling");
  nvm_order_a: assert property ($rose(o_nvm_we) |-> o_nvm_addr == 2'h0
    ##1 (o_nvm_we && o_nvm_addr == 2'h1) ##1 (o_nvm_we && o_nvm_addr == 2'h2)
    ##1 (o_nvm_we && o_nvm_addr == 2'h3) ##1 !o_nvm_we) else $error("store order wrong");
  cover property (o_segment == 2'h3);
  cover property ($rose(o_nvm_we));
  cover property ($fell(o_warn_nreach));
endmodule

/* File: test/tld_host_model.sv */
`timescale 1ns/1ps
// ****************************************
// host register master
// ****************************************
module tld_host_model (
  // clock
  input  wire        i_ref_clk,
  // register port
  input  wire [31:0] i_rdata,
  output reg  [7:0]  o_addr,
  output reg  [31:0] o_wdata,
  output reg         o_wr,
  output reg         o_rd
);
  initial begin
    o_addr = 8'h00;
    o_wdata = 32'h00000000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // released lines show the inverse so stale values never pass
  task automatic wr(input [7:0] a, input [31:0] d);
    @(posedge i_ref_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_ref_clk);
    o_addr <= ~a;
    o_wdata <= ~d;
    o_wr <= 1'b0;
  endtask
  task automatic rd(input [7:0] a, output [31:0] d);
    @(posedge i_ref_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_ref_clk);
    o_addr <= ~a;
    o_rd <= 1'b0;
    // data stand between this edge and the next; take them at that edge
    @(posedge i_ref_clk);
    d = i_rdata;
  endtask
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/1ps
// ****************************************
// top level bench
// ****************************************
module tb_top;
  reg         i_ref_clk, i_srst, i_reg_tick;
  reg  [31:0] i_meas_pos, i_meas_spd;
  wire [7:0]  i_addr;
  wire [31:0] i_wdata, o_rdata, o_setpoint_spd, o_ratio, o_nvm_data;
  wire        i_wr, i_rd, o_warn_nreach, o_nvm_we, o_nvm_bank, o_irq;
  wire [1:0]  o_segment, o_nvm_addr;
  integer     failures, checks_done, seed, i, b;
  reg  [31:0] d, e, r, sh [1:4];
  reg  [7:0]  a;
  reg  [3:0]  seen;
  reg  [1:0]  tcnt;
  tld_top u_tld_top (.i_ref_clk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_reg_tick,
    .i_meas_pos, .i_meas_spd, .o_setpoint_spd, .o_segment, .o_warn_nreach, .o_ratio, .o_nvm_we,
    .o_nvm_bank, .o_nvm_addr, .o_nvm_data, .o_irq);
  tld_host_model u_host (.i_ref_clk, .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
    .o_wr(i_wr), .o_rd(i_rd));
  task chk(input [31:0] g, input [31:0] x);
    begin
      checks_done = checks_done + 1;
      if (g !== x) begin
        failures = failures + 1;
        $display("ERROR %0t got %h expected %h", $time, g, x);
      end
    end
  endtask
  function [31:0] clampv(input [7:0] ad, input [31:0] v);
    clampv = (ad != 8'h44 && v[31]) ? 32'h00000000 : v;
  endfunction
  task rdc(input [7:0] ad, input [31:0] x);
    begin
      u_host.rd(ad, d);
      chk(d, x);
    end
  endtask
  // ticks come every fourth cycle, so wait whole tick periods
  task tk(input integer n);
    begin
      repeat (4 * n) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      tcnt       <= 2'd0;
      i_reg_tick <= 1'b0;
    end else begin
      tcnt       <= tcnt + 2'd1;
      i_reg_tick <= (tcnt == 2'd3);
    end
  end
  initial begin
    #400000;
    failures = failures + 1;
    summarize;
  end
  initial begin
    failures = 0;
    checks_done = 0;
    seed = 96;
    i_srst = 1'b1;
    i_meas_pos = 32'h00000000;
    i_meas_spd = 32'h00000000;
    sh[1] = 32'h00000000;
    sh[2] = 32'h07FFFFFF;
    sh[3] = 32'h00000001;
    sh[4] = 32'h00010000;
    repeat (2) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    for (i = 1; i < 5; i = i + 1) rdc(8'h40 + i[7:0], sh[i]);
    for (i = 0; i < 16; i = i + 1) begin
      r = $random(seed);
      a = 8'h41 + {6'h00, r[1:0]};
      r = (i < 4) ? 32'h80000000 : $random(seed);
      u_host.wr(a, r);
      sh[a[2:0]] = clampv(a, r);
      rdc(a, sh[a[2:0]]);
    end
    rdc(8'h3F, 32'h00000000);
    $display("test registers done");
    sh[1] = 32'h00000100;
    sh[2] = 32'h00000064;
    sh[3] = 32'h00000005;
    for (i = 1; i < 5; i = i + 1) u_host.wr(8'h40 + i[7:0], sh[i]);
    u_host.wr(8'h40, 32'h00100000);
    u_host.wr(8'h51, 32'h00001388);
    u_host.wr(8'h50, 32'h00000001);
    seen = 4'h0;
    for (i = 0; i < 30; i = i + 1) begin
      tk(1);
      seen[o_segment] = 1'b1;
      chk({31'h0, $signed(o_setpoint_spd) <= 100}, 1);
    end
    chk(seen[2:1], 2'b11);
    chk(o_ratio, sh[4]);
    i_meas_pos <= 32'h0000137E;
    tk(2);
    e = o_setpoint_spd;
    tk(1);
    chk(o_segment, 2'h3);
    chk(o_setpoint_spd, e - 32'h1);
    for (i = 0; i < 3; i = i + 1) begin
      i_meas_pos <= 32'h00001388 + i[31:0] * 5;
      tk(3);
      chk(o_warn_nreach, i == 2);
      if (i < 2) chk(o_setpoint_spd, 32'h00000000);
    end
    u_host.wr(8'h51, 32'h00000032);
    u_host.wr(8'h50, 32'h00000002);
    for (i = 0; i < 2; i = i + 1) begin
      i_meas_spd <= i ? 32'h0000003C : 32'h0000002D;
      tk(2);
      chk(o_warn_nreach, i);
    end
    $display("test motion done");
    u_host.wr(8'h50, 32'h00000000);
    for (b = 0; b < 2; b = b + 1) begin
      u_host.wr(8'h55, 32'h00000007);
      u_host.wr(8'h56, 32'h00000004);
      u_host.wr(8'h57, 32'h1 << b);
      i = 0;
      while (!o_nvm_we && i < 20) begin
        @(negedge i_ref_clk);
        i = i + 1;
      end
      for (i = 1; i < 5; i = i + 1) begin
        chk({31'h0, o_nvm_bank}, {31'h0, b[0]});
        chk(o_nvm_data, sh[i]);
        @(negedge i_ref_clk);
      end
      repeat (3) @(negedge i_ref_clk);
      chk(o_irq, 1);
      u_host.rd(8'h54, d);
      chk(d[2], 1);
      u_host.wr(8'h56, 32'h00000000);
      repeat (2) @(negedge i_ref_clk);
      chk(o_irq, 0);
      u_host.wr(8'h56, 32'h00000004);
      u_host.wr(8'h55, 32'h00000004);
      repeat (2) @(negedge i_ref_clk);
      chk(o_irq, 0);
    end
    $display("test store done");
    summarize;
  end
endmodule
bind tld_top tld_top_props u_tld_top_props (.i_ref_clk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .i_reg_tick, .o_setpoint_spd, .o_segment, .o_warn_nreach, .o_ratio, .o_nvm_we,
  .o_nvm_addr);
